// [design/radio_adapter_regs.svh]
// Register addresses, reset values, field positions and timing counts of the radio adapter control core.
`ifndef RADIO_ADAPTER_REGS_SVH
`define RADIO_ADAPTER_REGS_SVH
`define ADDR_ENABLE_PULSE_START 5'h08
`define ADDR_ENABLE_PULSE_WIDTH 5'h09
`define ADDR_SWITCH_START 5'h0A
`define ADDR_SLICER_START 5'h0B
`define ADDR_SECOND_PULSE_START 5'h0C
`define ADDR_STRENGTH_POSITION 5'h0D
`define ADDR_STATIC_LOW 5'h0E
`define ADDR_STATIC_MID 5'h0F
`define ADDR_STATIC_HIGH 5'h10
`define ADDR_CHANNEL 5'h12
`define ADDR_TRIM_ID 5'h13
`define ADDR_CLOCK_CONTROL 5'h16
`define ADDR_POWER_AMP 5'h18
`define ADDR_ENABLES 5'h19
`define ADDR_SHAPING_BIAS_START 5'h1A
`define ADDR_SHAPING_TABLE 5'h1C
`define ADDR_RX_OFFSET 5'h1E
`define ADDR_TX_OFFSET 5'h1F
`define RST_ENABLE_PULSE_START 8'h0C
`define RST_ENABLE_PULSE_WIDTH 8'hC8
`define RST_SWITCH_START 8'h64
`define RST_SLICER_START 8'h0A
`define RST_SECOND_PULSE_START 8'h02
`define RST_STRENGTH_POSITION 8'h64
`define RST_STATIC_LOW 8'h24
`define RST_STATIC_MID 8'h12
`define RST_STATIC_HIGH 8'h00
`define RST_CHANNEL 8'h00
`define RST_TRIM 8'h80
`define RST_CLOCK_CONTROL 8'h00
`define RST_POWER_AMP 8'h00
`define RST_ENABLES 8'h00
`define RST_SHAPING_BIAS_START 8'h64
`define RST_SHAPING_TABLE 8'h00
`define RST_RX_OFFSET 8'h61
`define RST_TX_OFFSET 8'h60
// Identification code; this value is arbitrary.
`define ID_DEFAULT 8'h5A
`define RDY_BIT 0
`define TRX_BIT 7
`define CHANNEL_MSB 6
`define DIVIDER_BASE 12'h900
`define IR_CAPTURE_PATTERN 5'h01
`define IR_RESET_ADDR 5'h13
`define HOST_RESET_TICKS 3'h4
`define CLK_PERIOD_NS 20
`define SBUS_START_NS 350
`define SBUS_START_CYCLES ((`SBUS_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SBUS_LAST_BIT 6'h1F
`define SBUS_HALF_CYCLES 4
`define SYSCLK_HALF_CYCLES 2
`define LPO_HALF_CYCLES 7812
`endif

// [design/radio_adapter_pkg.sv]
// Types shared by the radio adapter control core.
package radio_adapter_pkg;
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
        TAP_SHIFT_DR = 4'h6, TAP_EXIT1_DR = 4'h7, TAP_PAUSE_DR = 4'h5, TAP_EXIT2_DR = 4'h4,
        TAP_UPD_DR = 4'hC, TAP_SEL_IR = 4'hD, TAP_CAP_IR = 4'hF, TAP_SHIFT_IR = 4'hE,
        TAP_EXIT1_IR = 4'hA, TAP_PAUSE_IR = 4'hB, TAP_EXIT2_IR = 4'h9, TAP_UPD_IR = 4'h8
    } tap_state_t;
    typedef enum logic [1:0] {
        SB_IDLE = 2'b00, SB_WAIT = 2'b01, SB_SHIFT = 2'b11, SB_DONE = 2'b10
    } sbus_state_t;
    typedef struct packed {
        logic [31:0][7:0] regs;
        logic [1:0] tck_s;
        logic [1:0] tms_s;
        logic [1:0] tdi_s;
        logic [1:0] req_s;
        logic [1:0] synth_s;
        logic [1:0] hrst_s;
        logic tck_prev;
        logic synth_prev;
        tap_state_t tap;
        logic [4:0] ir;
        logic [4:0] ir_sh;
        logic [7:0] dr;
        logic tdo;
        logic trx;
        logic [7:0] div;
        sbus_state_t sb;
        logic [31:0] sh;
        logic [5:0] bitn;
        logic [4:0] wait_cnt;
        logic [2:0] ph;
        logic sclk;
        logic sdata;
        logic sstb;
        logic [1:0] sys_ph;
        logic sys_tog;
        logic sys_out;
        logic [2:0] hr_ticks;
        logic por_out;
        logic [12:0] lpo_cnt;
        logic lpo;
    } state_t;
endpackage

// [design/radio_adapter_control.sv]
// Control core of the radio adapter: resets, clock gating, scan-port register bank and radio word sender.
`timescale 1ns/1ps
`include "radio_adapter_regs.svh"
module radio_adapter_control
    import radio_adapter_pkg::*;
#(
    parameter int LPO_HALF_CYCLES = `LPO_HALF_CYCLES,  // Low-power clock half period in clk cycles.
    parameter logic [7:0] ID_CODE = `ID_DEFAULT        // Identification code, arbitrary value.
) (
    input wire logic clk,                      // 50 MHz core clock.
    input wire logic rst_n,                    // Power-on reset from supply sense, active low.
    input wire logic host_reset_in,            // External host reset, active high, asynchronous pin.
    input wire logic clock_request_in,         // System clock request from the controller.
    input wire logic input_a,                  // Synthesiser-on from the controller.
    input wire logic tck,                      // Scan port clock.
    input wire logic tms,                      // Scan port mode select.
    input wire logic tdi,                      // Scan port data in.
    input wire logic [7:0] signal_strength_in, // Converted signal-strength result.
    output logic tdo,                          // Scan port data out.
    output logic system_clock_out,             // Gated system clock.
    output logic low_power_clock_out,          // Low-power clock.
    output logic system_reset_out,             // Reset toward the system, active high.
    output logic sbus_clk,                     // Radio serial clock.
    output logic sbus_data,                    // Radio serial data.
    output logic sbus_strobe,                  // Radio serial word strobe, high over the word.
    output logic [7:0] oscillator_trim,        // Oscillator trim value.
    output logic [7:0] power_amp_level         // Power amplifier level.
);
    localparam logic [4:0] SBUS_WAIT_LAST = 5'(`SBUS_START_CYCLES - 1);
    localparam logic [2:0] SBUS_HALF = 3'(`SBUS_HALF_CYCLES - 1);
    localparam logic [2:0] SBUS_FULL = 3'(2 * `SBUS_HALF_CYCLES - 1);
    localparam logic [1:0] SYS_HALF = 2'(`SYSCLK_HALF_CYCLES - 1);
    localparam logic [12:0] LPO_LAST = 13'(LPO_HALF_CYCLES - 1);

    // Builds the state taken at either reset.
    function automatic state_t reset_state();
        state_t s;
        s = '0;
        s.regs[`ADDR_ENABLE_PULSE_START] = `RST_ENABLE_PULSE_START;
        s.regs[`ADDR_ENABLE_PULSE_WIDTH] = `RST_ENABLE_PULSE_WIDTH;
        s.regs[`ADDR_SWITCH_START] = `RST_SWITCH_START;
        s.regs[`ADDR_SLICER_START] = `RST_SLICER_START;
        s.regs[`ADDR_SECOND_PULSE_START] = `RST_SECOND_PULSE_START;
        s.regs[`ADDR_STRENGTH_POSITION] = `RST_STRENGTH_POSITION;
        s.regs[`ADDR_STATIC_LOW] = `RST_STATIC_LOW;
        s.regs[`ADDR_STATIC_MID] = `RST_STATIC_MID;
        s.regs[`ADDR_STATIC_HIGH] = `RST_STATIC_HIGH;
        s.regs[`ADDR_CHANNEL] = `RST_CHANNEL;
        s.regs[`ADDR_TRIM_ID] = `RST_TRIM;
        s.regs[`ADDR_CLOCK_CONTROL] = `RST_CLOCK_CONTROL;
        s.regs[`ADDR_POWER_AMP] = `RST_POWER_AMP;
        s.regs[`ADDR_ENABLES] = `RST_ENABLES;
        s.regs[`ADDR_SHAPING_BIAS_START] = `RST_SHAPING_BIAS_START;
        s.regs[`ADDR_SHAPING_TABLE] = `RST_SHAPING_TABLE;
        s.regs[`ADDR_RX_OFFSET] = `RST_RX_OFFSET;
        s.regs[`ADDR_TX_OFFSET] = `RST_TX_OFFSET;
        s.tap = TAP_RESET;
        s.ir = `IR_RESET_ADDR;
        s.sb = SB_IDLE;
        return s;
    endfunction

    localparam state_t RESET_STATE = reset_state();

    // True for addresses that hold a writable register.
    function automatic logic is_writable(input logic [4:0] a);
        case (a)
            `ADDR_ENABLE_PULSE_START, `ADDR_ENABLE_PULSE_WIDTH, `ADDR_SWITCH_START, `ADDR_SLICER_START,
            `ADDR_SECOND_PULSE_START, `ADDR_STRENGTH_POSITION, `ADDR_STATIC_LOW, `ADDR_STATIC_MID,
            `ADDR_STATIC_HIGH, `ADDR_CHANNEL, `ADDR_TRIM_ID, `ADDR_CLOCK_CONTROL, `ADDR_POWER_AMP,
            `ADDR_ENABLES, `ADDR_SHAPING_BIAS_START, `ADDR_SHAPING_TABLE, `ADDR_RX_OFFSET,
            `ADDR_TX_OFFSET: is_writable = 1'b1;
            default: is_writable = 1'b0;
        endcase
    endfunction

    // Read value of an address; write-only registers read as zero.
    function automatic logic [7:0] read_value(input logic [31:0][7:0] r, input logic [4:0] a,
                                              input logic [7:0] signal_strength_result);
        case (a)
            `ADDR_CHANNEL: read_value = signal_strength_result;
            `ADDR_TRIM_ID: read_value = ID_CODE;
            `ADDR_RX_OFFSET, `ADDR_TX_OFFSET: read_value = 8'h00;
            default: read_value = is_writable(a) ? r[a] : 8'h00;
        endcase
    endfunction

    // Standard test access port state transitions.
    function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
        case (s)
            TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            default: tap_next = TAP_RESET;
        endcase
    endfunction

    state_t q;
    state_t next_q;
    state_t keep;
    logic tck_rise;
    logic tck_fall;
    logic synth_rise;
    logic sys_tick;
    logic host_rst;
    logic rdy;
    logic [11:0] divider;
    logic [7:0] wdata;

    // Next-state logic; every scan, clock request, synthesiser and host reset input passes two flip-flops before use.
    always_comb begin
        next_q = q;
        keep = q;
        divider = 12'h000;
        wdata = 8'h00;
        next_q.tck_s = {q.tck_s[0], tck};
        next_q.tms_s = {q.tms_s[0], tms};
        next_q.tdi_s = {q.tdi_s[0], tdi};
        next_q.req_s = {q.req_s[0], clock_request_in};
        next_q.synth_s = {q.synth_s[0], input_a};
        next_q.hrst_s = {q.hrst_s[0], host_reset_in};
        next_q.tck_prev = q.tck_s[1];
        next_q.synth_prev = q.synth_s[1];
        tck_rise = q.tck_s[1] & ~q.tck_prev;
        tck_fall = ~q.tck_s[1] & q.tck_prev;
        synth_rise = q.synth_s[1] & ~q.synth_prev;
        host_rst = q.hrst_s[1];
        rdy = q.regs[`ADDR_CLOCK_CONTROL][`RDY_BIT];

        // The oscillator divider always runs; only the output copy is gated.
        sys_tick = (q.sys_ph == SYS_HALF);
        next_q.sys_ph = sys_tick ? 2'h0 : 2'(q.sys_ph + 2'h1);
        next_q.sys_tog = sys_tick ? ~q.sys_tog : q.sys_tog;
        next_q.sys_out = next_q.sys_tog & (~rdy | q.req_s[1]);

        // Reset output counts rising system clock edges while host reset is held.
        if (host_rst) begin
            if (sys_tick && !q.sys_tog && q.hr_ticks != `HOST_RESET_TICKS) begin
                next_q.hr_ticks = 3'(q.hr_ticks + 3'h1);
            end
            next_q.por_out = (next_q.hr_ticks == `HOST_RESET_TICKS);
            next_q.lpo_cnt = 13'h0000;
            next_q.lpo = 1'b0;
        end else begin
            next_q.hr_ticks = 3'h0;
            next_q.por_out = 1'b0;
            next_q.lpo_cnt = (q.lpo_cnt == LPO_LAST) ? 13'h0000 : 13'(q.lpo_cnt + 13'h0001);
            next_q.lpo = (q.lpo_cnt == LPO_LAST) ? ~q.lpo : q.lpo;
        end

        // Scan port: the selected address stays in the instruction register for data-only scans.
        if (tck_rise) begin
            next_q.tap = tap_next(q.tap, q.tms_s[1]);
            case (q.tap)
                TAP_RESET: next_q.ir = `IR_RESET_ADDR;
                TAP_CAP_IR: next_q.ir_sh = `IR_CAPTURE_PATTERN;
                TAP_SHIFT_IR: next_q.ir_sh = {q.tdi_s[1], q.ir_sh[4:1]};
                TAP_UPD_IR: next_q.ir = q.ir_sh;
                TAP_CAP_DR: next_q.dr = read_value(q.regs, q.ir, signal_strength_in);
                TAP_SHIFT_DR: next_q.dr = {q.tdi_s[1], q.dr[7:1]};
                TAP_UPD_DR: begin
                    wdata = q.dr;
                    if (is_writable(q.ir)) begin
                        next_q.regs[q.ir] = wdata;
                    end
                    if (q.ir == `ADDR_CHANNEL) begin
                        // Conversion happens at the write so the sender only latches finished values.
                        divider = `DIVIDER_BASE + {5'h00, wdata[`CHANNEL_MSB:0]} +
                                  {4'h0, (wdata[`TRX_BIT] ? q.regs[`ADDR_RX_OFFSET]
                                                         : q.regs[`ADDR_TX_OFFSET])};
                        next_q.trx = wdata[`TRX_BIT];
                        next_q.div = divider[7:0];
                    end
                end
                default: next_q.tap = next_q.tap;
            endcase
        end
        // Data out changes on the falling scan clock so the master samples it stably.
        if (tck_fall) begin
            if (q.tap == TAP_SHIFT_IR) begin
                next_q.tdo = q.ir_sh[0];
            end else if (q.tap == TAP_SHIFT_DR) begin
                next_q.tdo = q.dr[0];
            end
        end

        // Radio serial sender; a new synthesiser edge during a send is ignored.
        case (q.sb)
            SB_IDLE: begin
                if (synth_rise) begin
                    next_q.sb = SB_WAIT;
                    next_q.wait_cnt = 5'h00;
                    next_q.sh = {q.regs[`ADDR_STATIC_HIGH], q.regs[`ADDR_STATIC_MID],
                                 q.regs[`ADDR_STATIC_LOW][7:1], q.trx, q.div};
                end
            end
            SB_WAIT: begin
                next_q.wait_cnt = 5'(q.wait_cnt + 5'h01);
                if (q.wait_cnt == SBUS_WAIT_LAST) begin
                    next_q.sb = SB_SHIFT;
                    next_q.sstb = 1'b1;
                    next_q.sdata = q.sh[31];
                    next_q.ph = 3'h0;
                    next_q.bitn = 6'h00;
                end
            end
            SB_SHIFT: begin
                next_q.ph = 3'(q.ph + 3'h1);
                if (q.ph == SBUS_HALF) begin
                    next_q.sclk = 1'b1;
                end
                if (q.ph == SBUS_FULL) begin
                    next_q.sclk = 1'b0;
                    next_q.ph = 3'h0;
                    if (q.bitn == `SBUS_LAST_BIT) begin
                        next_q.sb = SB_DONE;
                        next_q.sstb = 1'b0;
                    end else begin
                        next_q.bitn = 6'(q.bitn + 6'h01);
                        next_q.sh = {q.sh[30:0], 1'b0};
                        next_q.sdata = q.sh[30];
                    end
                end
            end
            SB_DONE: begin
                next_q.sb = SB_IDLE;
                next_q.sdata = 1'b0;
            end
            default: next_q.sb = SB_IDLE;
        endcase

        // Host reset forces the power-on state but leaves synchronisers, the system clock pieces and the reset output count running.
        if (host_rst) begin
            keep = next_q;
            next_q = RESET_STATE;
            next_q.tck_s = keep.tck_s;
            next_q.tms_s = keep.tms_s;
            next_q.tdi_s = keep.tdi_s;
            next_q.req_s = keep.req_s;
            next_q.synth_s = keep.synth_s;
            next_q.hrst_s = keep.hrst_s;
            next_q.tck_prev = keep.tck_prev;
            next_q.synth_prev = keep.synth_prev;
            next_q.sys_ph = keep.sys_ph;
            next_q.sys_tog = keep.sys_tog;
            next_q.sys_out = keep.sys_tog;
            next_q.hr_ticks = keep.hr_ticks;
            next_q.por_out = keep.por_out;
        end
    end

    // State register; power-on reset loads the constant reset state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET_STATE;
        end else begin
            q <= next_q;
        end
    end

    assign tdo = q.tdo;
    assign system_clock_out = q.sys_out;
    assign low_power_clock_out = q.lpo;
    assign system_reset_out = q.por_out;
    assign sbus_clk = q.sclk;
    assign sbus_data = q.sdata;
    assign sbus_strobe = q.sstb;
    assign oscillator_trim = q.regs[`ADDR_TRIM_ID];
    assign power_amp_level = q.regs[`ADDR_POWER_AMP];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_clock_ungated;
        !q.regs[`ADDR_CLOCK_CONTROL][`RDY_BIT] |=> (system_clock_out == q.sys_tog);
    endproperty
    a_clock_ungated: assert property (p_clock_ungated) else $error("Clock gated before ready.");

    property p_clock_gated;
        q.regs[`ADDR_CLOCK_CONTROL][`RDY_BIT] && !q.req_s[1] && !q.hrst_s[1] |=> !system_clock_out;
    endproperty
    a_clock_gated: assert property (p_clock_gated) else $error("Clock not gated off by request.");

    property p_osc_runs;
        q.sys_tog |-> ##[1:2] !q.sys_tog;
    endproperty
    a_osc_runs: assert property (p_osc_runs) else $error("Oscillator stopped.");

    property p_reset_out_cause;
        $rose(system_reset_out) |-> $past(q.hrst_s[1], 8);
    endproperty
    a_reset_out_cause: assert property (p_reset_out_cause) else $error("Reset output without host reset.");

    property p_lpo_held;
        q.hrst_s[1] |=> !low_power_clock_out && (q.lpo_cnt == 13'h0000);
    endproperty
    a_lpo_held: assert property (p_lpo_held) else $error("Low-power clock ran under host reset.");

    property p_word_fields;
        (q.sb == SB_WAIT) |-> (q.sh[8:0] == {q.trx, q.div}) && (q.sh[31:24] == q.regs[`ADDR_STATIC_HIGH]);
    endproperty
    a_word_fields: assert property (p_word_fields) else $error("Radio word fields wrong.");

    property p_start_delay;
        (q.sb == SB_IDLE) ##1 (q.sb == SB_WAIT) |-> (q.sb == SB_WAIT)[*8] ##11 (q.sb == SB_SHIFT);
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("Serial start delay wrong.");

    property p_strobe_frame;
        (q.sb == SB_SHIFT) |-> sbus_strobe;
    endproperty
    a_strobe_frame: assert property (p_strobe_frame) else $error("Strobe low during word.");

    property p_id_read;
        tck_rise && (q.tap == TAP_CAP_DR) && (q.ir == `ADDR_TRIM_ID) && !q.hrst_s[1] |=> (q.dr == ID_CODE);
    endproperty
    a_id_read: assert property (p_id_read) else $error("Identification read wrong.");

    property p_update_write;
        tck_rise && (q.tap == TAP_UPD_DR) && (q.ir == `ADDR_POWER_AMP) && !q.hrst_s[1]
            |=> (power_amp_level == $past(q.dr));
    endproperty
    a_update_write: assert property (p_update_write) else $error("Data update not written.");
endmodule

// [dv/jtag_master_model.sv]
// Behavioural scan-port master that stands in for the baseband controller.
`timescale 1ns/1ps
module jtag_master_model (
    input wire logic clk, // Core clock that paces the scan clock.
    input wire logic tdo, // Scan data from the adapter.
    output logic tck,     // Scan clock, held low between scans.
    output logic tms,     // Scan mode select.
    output logic tdi      // Scan data to the adapter.
);
    // The scan clock stands still low until a scan is made.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One scan clock of 8 core clocks, begun at a falling core edge; tdo is taken at the rising edge.
    task automatic pulse(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        q = tdo;
        tck = 1'b1;
        repeat (4) @(negedge clk);
        tck = 1'b0;
    endtask
    // Five high mode bits reach the reset state from anywhere, then park in idle.
    task automatic reset_tap();
        logic q;
        repeat (5) pulse(1'b1, 1'b0, q);
        pulse(1'b0, 1'b0, q);
    endtask
    // Only this adapter sits on the chain, so no bypass bits pad the shift.
    // Instruction or data scan from idle back to idle, least significant bit first.
    task automatic scan(input logic is_ir, input int n, input logic [7:0] wr, output logic [7:0] rd);
        logic q;
        rd = 8'h00;
        pulse(1'b1, 1'b0, q);
        if (is_ir) pulse(1'b1, 1'b0, q);
        pulse(1'b0, 1'b0, q);
        pulse(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, wr[i], q);
            rd[i] = q;
        end
        pulse(1'b1, 1'b0, q);
        pulse(1'b0, 1'b0, q);
    endtask
endmodule

// [dv/tb_top.sv]
// Self-checking testbench of the radio adapter control core.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic host_reset_in = 1'b0;
    logic clock_request_in = 1'b0;
    logic input_a = 1'b0;
    logic tck, tms, tdi, tdo;
    logic system_clock_out, low_power_clock_out, system_reset_out, sbus_clk, sbus_data, sbus_strobe;
    logic [7:0] rd;
    logic [7:0] trim;
    logic [7:0] pa;
    int failures = 0;
    int checks_done = 0;
    int n;
    always #10 clk = ~clk;
    radio_adapter_control #(.LPO_HALF_CYCLES(8), .ID_CODE(8'h5A)) i_radio_adapter_control (.clk(clk), .rst_n(rst_n),
        .host_reset_in(host_reset_in), .clock_request_in(clock_request_in), .input_a(input_a), .tck(tck), .tms(tms),
        .tdi(tdi), .signal_strength_in(8'h3C), .tdo(tdo), .system_clock_out(system_clock_out),
        .low_power_clock_out(low_power_clock_out), .system_reset_out(system_reset_out), .sbus_clk(sbus_clk),
        .sbus_data(sbus_data), .sbus_strobe(sbus_strobe), .oscillator_trim(trim), .power_amp_level(pa));
    jtag_master_model i_jtag_master_model (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
    // Counted comparison that reports a difference at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Full access: address into the instruction register, then one data byte; the read is the captured byte.
    task automatic acc(input logic [4:0] a, input logic [7:0] wr);
        i_jtag_master_model.scan(1'b1, 5, {3'h0, a}, rd);
        i_jtag_master_model.scan(1'b0, 8, wr, rd);
    endtask
    // Counts system clock output changes over 32 core clocks; running means 16.
    task automatic toggles(output int t);
        logic p;
        t = 0;
        p = system_clock_out;
        repeat (32) begin
            @(negedge clk);
            if (system_clock_out !== p) t++;
            p = system_clock_out;
        end
    endtask
    // Reset values, split read and write places, unmapped read and a data-only repeat access.
    task automatic t_regs();
        logic [4:0] ad [6] = '{5'h08, 5'h09, 5'h0E, 5'h0F, 5'h10, 5'h16};
        logic [7:0] rv [6] = '{8'h0C, 8'hC8, 8'h24, 8'h12, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            acc(ad[i], rv[i]);
            chk(rd, rv[i]);
        end
        acc(5'h13, 8'h4D);
        chk(rd, 8'h5A);
        chk(trim, 8'h4D);
        acc(5'h18, 8'h9C);
        chk(rd, 8'h00);
        chk(pa, 8'h9C);
        acc(5'h12, 8'h00);
        chk(rd, 8'h3C);
        acc(5'h11, 8'h77);
        chk(rd, 8'h00);
        acc(5'h0E, 8'hB6);
        i_jtag_master_model.scan(1'b0, 8, 8'h5B, rd);
        chk(rd, 8'hB6);
    endtask
    // Triggers one radio word, checks the start delay, the strobe framing and every bit, most significant first.
    task automatic send(input logic [31:0] exp);
        logic [31:0] w;
        n = 0;
        @(negedge clk);
        input_a = 1'b1;
        while (sbus_strobe !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk(n >= 18 && n <= 23, 32'h1);
        for (int i = 0; i < 32; i++) begin
            @(posedge sbus_clk);
            w = {w[30:0], sbus_data};
            chk(sbus_strobe, 1'b1);
        end
        chk(w, exp);
        @(negedge clk);
        input_a = 1'b0;
        repeat (12) @(negedge clk);
        chk(sbus_strobe, 1'b0);
    endtask
    // Static fields, transmit offset with a late offset rewrite, then receive with the reset offset.
    task automatic t_sends();
        logic [11:0] d;
        acc(5'h10, 8'hA5);
        acc(5'h0F, 8'h3C);
        acc(5'h1F, 8'hFF);
        acc(5'h12, 8'h7F);
        acc(5'h1F, 8'h10);
        d = 12'h900 + 12'h07F + 12'h0FF;
        send({8'hA5, 8'h3C, 7'h2D, 1'b0, d[7:0]});
        acc(5'h12, 8'h85);
        d = 12'h900 + 12'h005 + 12'h061;
        send({8'hA5, 8'h3C, 7'h2D, 1'b1, d[7:0]});
    endtask
    // Clock runs ungated until ready is set, then follows the request.
    task automatic t_clock();
        toggles(n);
        chk(n >= 12, 32'h1);
        acc(5'h16, 8'h01);
        repeat (8) @(negedge clk);
        toggles(n);
        chk(n, 32'h0);
        clock_request_in = 1'b1;
        repeat (8) @(negedge clk);
        toggles(n);
        chk(n >= 12, 32'h1);
        clock_request_in = 1'b0;
    endtask
    // Host reset: delayed reset output, quiet low-power clock, ungated clock and restored registers.
    task automatic t_host();
        logic p;
        host_reset_in = 1'b1;
        n = 0;
        while (system_reset_out !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk(n >= 12 && n <= 20, 32'h1);
        toggles(n);
        chk(n >= 12, 32'h1);
        chk(low_power_clock_out, 1'b0);
        host_reset_in = 1'b0;
        repeat (8) @(negedge clk);
        chk(system_reset_out, 1'b0);
        chk(trim, 8'h80);
        chk(pa, 8'h00);
        // Once host reset is gone the low-power clock must run again.
        n = 0;
        p = low_power_clock_out;
        repeat (32) begin
            @(negedge clk);
            if (low_power_clock_out !== p) n++;
            p = low_power_clock_out;
        end
        chk(n >= 3, 32'h1);
        // Host reset parked the scan port in its reset state, so the master must walk it back to idle.
        i_jtag_master_model.reset_tap();
        acc(5'h16, 8'h00);
        chk(rd, 8'h00);
        acc(5'h0E, 8'h24);
        chk(rd, 8'h24);
    endtask
    // Single place where the run ends.
    task automatic tally_and_finish();
        if (failures == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Main sequence after twelve cycles of power-on reset.
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        i_jtag_master_model.reset_tap();
        t_regs();
        t_sends();
        t_clock();
        t_host();
        tally_and_finish();
    end
    // Watchdog well beyond the expected run of some five thousand cycles.
    initial begin
        #1000000;
        failures++;
        tally_and_finish();
    end
endmodule
